// >>> hdl/flr_map.vh
// Register map, field positions, reset values and timing for the flash
// LED control register bank. Assumes an 8-bit register port.
`ifndef FLR_MAP_VH
`define FLR_MAP_VH

// Register offsets
`define FLR_ADDR_TIMER      8'h03
`define FLR_ADDR_LIMIT      8'h04
`define FLR_ADDR_CAL        8'h05

// Reset values
`define FLR_RST_TIMER       8'hC1
`define FLR_RST_LIMIT       8'h00
`define FLR_RST_CAL         8'h6A

// Field positions, timer register
`define FLR_TCODE_HI        7
`define FLR_TCODE_LO        5
`define FLR_RANGE_BIT       4
`define FLR_STT_BIT         2
`define FLR_SFT_BIT         1
`define FLR_BLANK_BIT       0

// Field positions, limit register
`define FLR_PG_BIT          7
`define FLR_VALLEY_LIMIT_SELECT_BIT        4
`define FLR_IND_HI          3

// Field positions, calibration register
`define FLR_CAL_BIT         7
`define FLR_PSM_BIT         6
`define FLR_DIR_BIT         5
`define FLR_GVAL_BIT        4
`define FLR_GTYPE_BIT       3
`define FLR_LEN_HI          2

// Operating modes
`define FLR_MODE_OFF        2'h0
`define FLR_MODE_DCL        2'h1
`define FLR_MODE_FLASH      2'h2

// Timeout tick is 0.1 ms; clock period 10 ns
`define FLR_TICK_NS         100000
`define FLR_CLK_NS          10

// Timeout table in 0.1 ms ticks, range 0
`define FLR_R0_0            14'd682
`define FLR_R0_1            14'd1022
`define FLR_R0_2            14'd1363
`define FLR_R0_3            14'd1704
`define FLR_R0_4            14'd2045
`define FLR_R0_5            14'd3408
`define FLR_R0_6            14'd5793
`define FLR_R0_7            14'd8520
// Range 1
`define FLR_R1_0            14'd53
`define FLR_R1_1            14'd107
`define FLR_R1_2            14'd160
`define FLR_R1_3            14'd213
`define FLR_R1_4            14'd266
`define FLR_R1_5            14'd320
`define FLR_R1_6            14'd373
`define FLR_R1_7            14'd2077

`endif

// >>> hdl/flr_top.v
// Flash LED control registers: safety timer and strobe, blanking,
// status flags, valley limit, privacy indicator, calibration, pin, enables.
// Assumes a serial bus slave in front gives one-cycle read/write strobes
// on clk_i; all status pins are asynchronous and synchronised here.
`timescale 1ns/1ps
`include "flr_map.vh"

module flr_top #(
    parameter TICK_CYCLES = `FLR_TICK_NS / `FLR_CLK_NS
) (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire [7:0] reg_addr_i,
    input  wire       reg_wr_i,
    input  wire       reg_rd_i,
    input  wire [7:0] reg_wdata_i,
    output reg  [7:0] reg_rdata_o,
    input  wire [1:0] mode_i,
    input  wire       flash_sync_i,
    input  wire       led_fault_i,
    input  wire       tx_mask_i,
    input  wire       high_current_select_i,
    input  wire       dc_light_input_i,
    input  wire       power_good_i,
    input  wire [1:0] die_temp_i,
    input  wire       thermal_trip_i,
    input  wire       cal_done_i,
    input  wire       gpio_i,
    output reg        strobe_active_o,
    output reg        current_reduce_o,
    output reg  [1:0] valley_limit_o,
    output reg  [1:0] indicator_level_o,
    output reg        indicator_pulldown_o,
    output reg        privacy_pwm_en_o,
    output reg  [2:0] privacy_pwm_code_o,
    output reg        cal_start_o,
    output reg        power_save_o,
    output reg        gpio_o,
    output reg        gpio_oe_o,
    output reg  [2:0] led_enable_o
);

    // ********************************************
    // Input synchronisers
    // ********************************************
    localparam NSYNC = 12;
    wire [NSYNC-1:0] async_in;
    reg  [NSYNC-1:0] sync1_reg;
    reg  [NSYNC-1:0] sync2_reg;
    assign async_in = {flash_sync_i, led_fault_i, tx_mask_i,
                       high_current_select_i, dc_light_input_i,
                       power_good_i, die_temp_i, thermal_trip_i,
                       cal_done_i, gpio_i, 1'b0};

    // Two flops per asynchronous pin
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            always @(posedge clk_i) begin
                if (rst_i) begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                end else begin
                    sync1_reg[gi] <= async_in[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate

    wire       trig_s  = sync2_reg[11];
    wire       fault_s = sync2_reg[10];
    wire       mask_s  = sync2_reg[9];
    wire       hcs_s   = sync2_reg[8];
    wire       dcl_s   = sync2_reg[7];
    wire       pg_s    = sync2_reg[6];
    wire [1:0] temp_s  = sync2_reg[5:4];
    wire       trip_s  = sync2_reg[3];
    wire       cdone_s = sync2_reg[2];
    wire       gpin_s  = sync2_reg[1];

    // ********************************************
    // Register port decode
    // ********************************************
    wire wr_tim = reg_wr_i && (reg_addr_i == `FLR_ADDR_TIMER);
    wire wr_lim = reg_wr_i && (reg_addr_i == `FLR_ADDR_LIMIT);
    wire wr_cal = reg_wr_i && (reg_addr_i == `FLR_ADDR_CAL);
    wire rd_tim = reg_rd_i && (reg_addr_i == `FLR_ADDR_TIMER);
    wire rd_lim = reg_rd_i && (reg_addr_i == `FLR_ADDR_LIMIT);

    // ********************************************
    // Control and status state
    // ********************************************
    // Reset images of the three registers
    localparam [7:0] RST_TIM = `FLR_RST_TIMER;
    localparam [7:0] RST_LIM = `FLR_RST_LIMIT;
    localparam [7:0] RST_CAL = `FLR_RST_CAL;
    reg [2:0]  tcode_reg;
    reg        range_reg;
    reg        stt_reg;
    reg        blank_en_reg;
    reg        fail_reg;
    reg        to_reg;
    reg        mask_evt_reg;
    reg        trip_reg;
    reg [1:0]  temp_d_reg;
    reg [1:0]  temp_ok_reg;
    reg        pg_route_reg;
    reg        valley_limit_select_reg;
    reg [3:0]  ind_reg;
    reg        started_reg;
    reg        cal_done_reg;
    reg        cal_run_reg;
    reg        psm_reg;
    reg        dir_reg;
    reg        gval_reg;
    reg        gtype_reg;
    reg [2:0]  len_reg;
    reg        active_reg;
    reg        trig_d_reg;
    reg [13:0] tick_cnt_reg;
    reg [31:0] div_cnt_reg;
    reg [13:0] limit_ticks;

    // Timeout length lookup in 0.1 ms ticks
    always @* begin
        case ({range_reg, tcode_reg})
            4'h0:    limit_ticks = `FLR_R0_0;
            4'h1:    limit_ticks = `FLR_R0_1;
            4'h2:    limit_ticks = `FLR_R0_2;
            4'h3:    limit_ticks = `FLR_R0_3;
            4'h4:    limit_ticks = `FLR_R0_4;
            4'h5:    limit_ticks = `FLR_R0_5;
            4'h6:    limit_ticks = `FLR_R0_6;
            4'h7:    limit_ticks = `FLR_R0_7;
            4'h8:    limit_ticks = `FLR_R1_0;
            4'h9:    limit_ticks = `FLR_R1_1;
            4'hA:    limit_ticks = `FLR_R1_2;
            4'hB:    limit_ticks = `FLR_R1_3;
            4'hC:    limit_ticks = `FLR_R1_4;
            4'hD:    limit_ticks = `FLR_R1_5;
            4'hE:    limit_ticks = `FLR_R1_6;
            default: limit_ticks = `FLR_R1_7;
        endcase
    end

    // Strobe start and end conditions
    wire flash_mode = (mode_i == `FLR_MODE_FLASH);
    wire sw_start   = wr_tim && reg_wdata_i[`FLR_SFT_BIT];
    wire pin_start  = flash_mode && trig_s &&
                      (stt_reg ? !trig_d_reg : 1'b1);
    wire lvl_drop   = flash_mode && !stt_reg && !trig_s &&
                      trig_d_reg;
    wire tick_end   = (div_cnt_reg == TICK_CYCLES - 1);
    wire expire     = active_reg && tick_end &&
                      (tick_cnt_reg == limit_ticks - 14'h0001);
    wire start      = !active_reg && (sw_start ||
                      (pin_start && (stt_reg || !trig_d_reg)));

    // Safety timer and strobe
    always @(posedge clk_i) begin
        if (rst_i) begin
            active_reg   <= 1'b0;
            trig_d_reg   <= 1'b0;
            tick_cnt_reg <= 14'h0000;
            div_cnt_reg  <= 32'h00000000;
            to_reg       <= 1'b0;
        end else begin
            trig_d_reg <= trig_s;
            if (start) begin
                active_reg   <= 1'b1;
                tick_cnt_reg <= 14'h0000;
                div_cnt_reg  <= 32'h00000000;
                to_reg       <= 1'b0;
            end else if (expire) begin
                active_reg <= 1'b0;
                to_reg     <= 1'b1;
            end else if (active_reg && lvl_drop) begin
                active_reg <= 1'b0;
            end else if (active_reg) begin
                if (tick_end) begin
                    div_cnt_reg  <= 32'h00000000;
                    tick_cnt_reg <= tick_cnt_reg + 14'h0001;
                end else begin
                    div_cnt_reg <= div_cnt_reg + 32'h00000001;
                end
            end
        end
    end

    // Writable fields of the three registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            tcode_reg    <= RST_TIM[`FLR_TCODE_HI:`FLR_TCODE_LO];
            range_reg    <= RST_TIM[`FLR_RANGE_BIT];
            stt_reg      <= RST_TIM[`FLR_STT_BIT];
            blank_en_reg <= RST_TIM[`FLR_BLANK_BIT];
            pg_route_reg <= RST_LIM[`FLR_PG_BIT];
            valley_limit_select_reg     <= RST_LIM[`FLR_VALLEY_LIMIT_SELECT_BIT];
            ind_reg      <= RST_LIM[`FLR_IND_HI:0];
            started_reg  <= 1'b0;
            psm_reg      <= RST_CAL[`FLR_PSM_BIT];
            dir_reg      <= RST_CAL[`FLR_DIR_BIT];
            gval_reg     <= RST_CAL[`FLR_GVAL_BIT];
            gtype_reg    <= RST_CAL[`FLR_GTYPE_BIT];
            len_reg      <= RST_CAL[`FLR_LEN_HI:0];
        end else begin
            if (mode_i != `FLR_MODE_OFF)
                started_reg <= 1'b1;
            if (wr_tim) begin
                tcode_reg    <= reg_wdata_i[`FLR_TCODE_HI:`FLR_TCODE_LO];
                range_reg    <= reg_wdata_i[`FLR_RANGE_BIT];
                stt_reg      <= reg_wdata_i[`FLR_STT_BIT];
                blank_en_reg <= reg_wdata_i[`FLR_BLANK_BIT];
            end
            if (wr_lim) begin
                pg_route_reg <= reg_wdata_i[`FLR_PG_BIT];
                ind_reg      <= reg_wdata_i[`FLR_IND_HI:0];
                if (!started_reg && mode_i == `FLR_MODE_OFF)
                    valley_limit_select_reg <= reg_wdata_i[`FLR_VALLEY_LIMIT_SELECT_BIT];
            end
            if (wr_cal) begin
                psm_reg   <= reg_wdata_i[`FLR_PSM_BIT];
                dir_reg   <= reg_wdata_i[`FLR_DIR_BIT];
                gval_reg  <= reg_wdata_i[`FLR_GVAL_BIT];
                gtype_reg <= reg_wdata_i[`FLR_GTYPE_BIT];
                len_reg   <= reg_wdata_i[`FLR_LEN_HI:0];
            end
        end
    end

    // Sticky flags, set beats clear; temperature code taken when steady
    always @(posedge clk_i) begin
        if (rst_i) begin
            fail_reg     <= 1'b0;
            mask_evt_reg <= 1'b0;
            trip_reg     <= 1'b0;
            temp_d_reg   <= 2'h0;
            temp_ok_reg  <= 2'h0;
        end else begin
            fail_reg     <= fault_s | (fail_reg & ~rd_tim);
            mask_evt_reg <= mask_s | (mask_evt_reg & ~rd_tim);
            trip_reg     <= trip_s | (trip_reg & ~rd_lim);
            temp_d_reg   <= temp_s;
            if (temp_s == temp_d_reg)
                temp_ok_reg <= temp_s;
        end
    end

    // Self-calibration handshake
    wire cal_go = wr_cal && reg_wdata_i[`FLR_CAL_BIT];
    always @(posedge clk_i) begin
        if (rst_i) begin
            cal_done_reg <= 1'b0;
            cal_run_reg  <= 1'b0;
            cal_start_o  <= 1'b0;
        end else begin
            cal_start_o <= cal_go;
            if (cal_go) begin
                cal_run_reg  <= 1'b1;
                cal_done_reg <= 1'b0;
            end else if (cal_run_reg && cal_start_o == 1'b0 &&
                         cdone_s) begin
                cal_run_reg  <= 1'b0;
                cal_done_reg <= 1'b1;
            end
        end
    end

    // ********************************************
    // Read data
    // ********************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `FLR_ADDR_TIMER:
                    reg_rdata_o <= {tcode_reg, fail_reg, to_reg,
                                    stt_reg, active_reg,
                                    mask_evt_reg};
                `FLR_ADDR_LIMIT:
                    reg_rdata_o <= {pg_s,
                                    trip_reg ? 2'h3 : temp_ok_reg,
                                    valley_limit_select_reg, ind_reg};
                `FLR_ADDR_CAL:
                    reg_rdata_o <= {cal_done_reg, psm_reg,
                                    dcl_s,
                                    dir_reg ? gval_reg : gpin_s,
                                    gtype_reg, len_reg};
                default:
                    reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // ********************************************
    // Registered outputs
    // ********************************************
    wire gsrc = pg_route_reg ? gval_reg : pg_s;
    always @(posedge clk_i) begin
        if (rst_i) begin
            strobe_active_o      <= 1'b0;
            current_reduce_o     <= 1'b0;
            valley_limit_o       <= {1'b1, RST_LIM[`FLR_VALLEY_LIMIT_SELECT_BIT]};
            indicator_level_o    <= 2'h0;
            indicator_pulldown_o <= 1'b0;
            privacy_pwm_en_o     <= 1'b0;
            privacy_pwm_code_o   <= 3'h0;
            power_save_o         <= RST_CAL[`FLR_PSM_BIT];
            gpio_o               <= 1'b0;
            gpio_oe_o            <= 1'b0;
            led_enable_o         <= 3'h0;
        end else begin
            strobe_active_o  <= active_reg && !expire;
            current_reduce_o <= blank_en_reg && mask_s;
            valley_limit_o   <= {~(hcs_s & mask_s), valley_limit_select_reg};
            // Indicator sink; pulled codes only with high current low
            if (!ind_reg[3] && !(ind_reg[2] && hcs_s))
                indicator_level_o <= ind_reg[1:0];
            else
                indicator_level_o <= 2'h0;
            indicator_pulldown_o <= !ind_reg[3] && ind_reg[2] &&
                                    (ind_reg[1:0] != 2'h0) &&
                                    !hcs_s;
            privacy_pwm_en_o   <= ind_reg[3] && !dcl_s &&
                                  (mode_i == `FLR_MODE_DCL);
            privacy_pwm_code_o <= ind_reg[2:0];
            power_save_o       <= psm_reg;
            gpio_o             <= gtype_reg ? 1'b0 : gsrc;
            gpio_oe_o          <= dir_reg &&
                                  (gtype_reg ? !gsrc : 1'b1);
            led_enable_o       <= len_reg;
        end
    end

endmodule // flr_top

// >>> verif/flr_top_chk.sv
// Concurrent checks on the ports of the flash LED register bank.
// Assumes it is bound into flr_top with the same TICK_CYCLES.
`timescale 1ns/1ps
module flr_chk #(
    parameter TICK_CYCLES = 2
) (
    input wire       clk_i,
    input wire       rst_i,
    input wire [7:0] reg_addr_i,
    input wire       reg_wr_i,
    input wire       reg_rd_i,
    input wire [7:0] reg_wdata_i,
    input wire [7:0] reg_rdata_o,
    input wire [1:0] mode_i,
    input wire       tx_mask_i,
    input wire       high_current_select_i,
    input wire       power_good_i,
    input wire       strobe_active_o,
    input wire       current_reduce_o,
    input wire [1:0] valley_limit_o,
    input wire       privacy_pwm_en_o,
    input wire       cal_start_o,
    input wire [2:0] led_enable_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ****************************************
    // Strobe length counter
    // ****************************************
    localparam int LIM = 8520 * TICK_CYCLES + 4;
    reg [31:0] run_reg;
    always @(posedge clk_i) begin
        if (rst_i || !strobe_active_o) begin
            run_reg <= 32'h0;
        end else begin
            run_reg <= run_reg + 32'h1;
        end
    end
    // Register write and strobe start from idle
    sequence s_wr5;
        reg_wr_i && reg_addr_i == 8'h05;
    endsequence
    sequence s_go;
        $past(mode_i) == 2'h0 && !$past(reg_wr_i) && mode_i == 2'h0
        && !strobe_active_o && reg_wr_i && reg_addr_i == 8'h03
        && reg_wdata_i[1];
    endsequence
    property p_valley;
        (high_current_select_i && tx_mask_i)[*4] |-> !valley_limit_o[1];
    endproperty
    property p_reduce;
        (!tx_mask_i)[*4] |-> !current_reduce_o;
    endproperty
    property p_pwm;
        (mode_i != 2'h1)[*3] |-> !privacy_pwm_en_o;
    endproperty
    property p_cal;
        cal_start_o |-> $past(reg_wr_i) && $past(reg_addr_i) == 8'h05
            && $past(reg_wdata_i[7]);
    endproperty
    property p_cal_go;
        reg_wr_i && reg_addr_i == 8'h05 && reg_wdata_i[7] |=> cal_start_o;
    endproperty
    property p_led;
        s_wr5 ##1 !(reg_wr_i && reg_addr_i == 8'h05)
            |=> led_enable_o == $past(reg_wdata_i[2:0], 2);
    endproperty
    property p_go;
        s_go |-> ##2 strobe_active_o;
    endproperty
    property p_tmo;
        strobe_active_o |-> run_reg < LIM;
    endproperty
    property p_pg;
        (power_good_i[*5] ##0 (reg_rd_i && reg_addr_i == 8'h04))
            ##1 !reg_rd_i |=> reg_rdata_o[7];
    endproperty
    a_valley: assert property (p_valley) else $error("valley low");
    a_reduce: assert property (p_reduce) else $error("reduce on");
    a_pwm: assert property (p_pwm) else $error("dimming on");
    a_cal: assert property (p_cal) else $error("stray cal start");
    a_cal_go: assert property (p_cal_go) else $error("no cal start");
    a_led: assert property (p_led) else $error("led enables");
    a_go: assert property (p_go) else $error("strobe not on");
    a_tmo: assert property (p_tmo) else $error("strobe too long");
    a_pg: assert property (p_pg) else $error("power good read");
endmodule // flr_chk

// >>> verif/flr_host.sv
// Host model: drives the register strobe port, one request at a time.
// Assumes the clock of the block; inputs change at the falling edge.
`timescale 1ns/1ps
module flr_host (
    input  wire       clk_i,
    input  wire [7:0] rdata_i,
    output reg  [7:0] addr_o,
    output reg        wr_o,
    output reg        rd_o,
    output reg  [7:0] wdata_o
);
    // Idle port: strobes low, address and data scrambled
    initial begin
        addr_o = 8'hA5;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 8'h5A;
    end
    // One write, taken at the rising edge in the middle
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(negedge clk_i);
            addr_o = a;
            wdata_o = d;
            wr_o = 1'b1;
            @(negedge clk_i);
            wr_o = 1'b0;
            addr_o = ~a;
            wdata_o = ~d;
        end
    endtask
    // One read, data taken once it has settled
    task rd(input [7:0] a, output [7:0] d);
        begin
            @(negedge clk_i);
            addr_o = a;
            rd_o = 1'b1;
            @(negedge clk_i);
            rd_o = 1'b0;
            addr_o = ~a;
            @(negedge clk_i);
            d = rdata_i;
        end
    endtask
endmodule // flr_host

// >>> verif/flr_top_tb.sv
// Self-checking bench for the flash LED control register bank.
// Assumes flr_top, flr_host and flr_chk are compiled before it.
`timescale 1ns/1ps
`include "flr_map.vh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
    bad_count++; $display("[FAIL] %0t got %0h exp %0h", $time, a, e); \
    end end
module flr_top_tb;
    localparam TK = 2;
    reg        clk_i, rst_i, flash_sync_i, led_fault_i, tx_mask_i;
    reg        high_current_select_i, dc_light_input_i, power_good_i;
    reg        thermal_trip_i, cal_done_i, gpio_i;
    reg  [1:0] mode_i, die_temp_i;
    wire [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    wire       reg_wr_i, reg_rd_i, strobe_active_o, current_reduce_o;
    wire       indicator_pulldown_o, privacy_pwm_en_o, cal_start_o;
    wire       power_save_o, gpio_o, gpio_oe_o;
    wire [1:0] valley_limit_o, indicator_level_o;
    wire [2:0] privacy_pwm_code_o, led_enable_o;
    int        bad_count = 0;
    int        checks_done = 0;
    int        i, n;
    reg  [7:0] d;
    reg  [3:0] c;
    time       t0;
    flr_top #(.TICK_CYCLES(TK)) dut (.*);
    flr_host host (.clk_i(clk_i), .rdata_i(reg_rdata_o),
        .addr_o(reg_addr_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i),
        .wdata_o(reg_wdata_i));
    // ****************************************
    // Clock, helpers, verdict
    // ****************************************
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task cyc(input int k);
        repeat (k) @(negedge clk_i);
    endtask
    task tdone(input string s);
        $display("test %s done", s);
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Watchdog far beyond the expected run
    initial begin
        repeat (30000) @(posedge clk_i);
        bad_count++;
        print_verdict;
    end
    // Main sequence
    initial begin
        {rst_i, mode_i, die_temp_i} = 5'h10;
        {flash_sync_i, led_fault_i, tx_mask_i, high_current_select_i} = 0;
        {dc_light_input_i, power_good_i, thermal_trip_i} = 3'h0;
        {cal_done_i, gpio_i} = 2'h0;
        cyc(6);
        rst_i = 1'b0;
        host.rd(`FLR_ADDR_TIMER, d);
        `CHK(d, 8'hC0)
        host.rd(`FLR_ADDR_LIMIT, d);
        `CHK(d, `FLR_RST_LIMIT)
        host.rd(`FLR_ADDR_CAL, d);
        `CHK(d, 8'h4A)
        `CHK({valley_limit_o, power_save_o}, 3'b101)
        host.rd(8'h07, d);
        `CHK(d, 8'h00)
        tdone("reset");
        // Strobe in range 1 then range 0, each ended by the timer
        for (i = 0; i < 2; i++) begin
            n = i ? `FLR_R0_0 : `FLR_R1_0;
            host.wr(`FLR_ADDR_TIMER, i ? 8'h02 : 8'h12);
            t0 = $time;
            host.rd(`FLR_ADDR_TIMER, d);
            `CHK(d[3:1], 3'b001)
            repeat (20000) if (strobe_active_o) @(negedge clk_i);
            n = int'(($time - t0) / 10) - n * TK;
            `CHK(n >= -3 && n <= 3, 1'b1)
            host.rd(`FLR_ADDR_TIMER, d);
            `CHK(d[3:1], 3'b100)
            host.rd(`FLR_ADDR_TIMER, d);
            `CHK(d[3], 1'b1)
        end
        tdone("strobe");
        // Failure and blanking event flags clear on read
        {led_fault_i, tx_mask_i} = 2'h3;
        cyc(4);
        {led_fault_i, tx_mask_i} = 2'h0;
        cyc(4);
        host.rd(`FLR_ADDR_TIMER, d);
        `CHK(d & 8'h11, 8'h11)
        host.rd(`FLR_ADDR_TIMER, d);
        `CHK(d & 8'h11, 8'h00)
        // Blanking enabled, then disabled
        for (i = 1; i >= 0; i--) begin
            host.wr(`FLR_ADDR_TIMER, i[7:0]);
            tx_mask_i = 1'b1;
            cyc(4);
            `CHK(current_reduce_o, i[0])
            tx_mask_i = 1'b0;
            cyc(4);
            `CHK(current_reduce_o, 1'b0)
        end
        tdone("flags");
        // Valley limit, then locked once running
        host.wr(`FLR_ADDR_LIMIT, 8'h10);
        {high_current_select_i, tx_mask_i} = 2'h3;
        cyc(4);
        `CHK(valley_limit_o, 2'h1)
        tx_mask_i = 1'b0;
        cyc(4);
        `CHK(valley_limit_o, 2'h3)
        mode_i = `FLR_MODE_DCL;
        host.wr(`FLR_ADDR_LIMIT, 8'h00);
        cyc(4);
        `CHK(valley_limit_o, 2'h3)
        // Indicator codes with the high-current select low, then high
        high_current_select_i = 1'b0;
        for (i = 0; i < 16; i++) begin
            c = i[3:0];
            host.wr(`FLR_ADDR_LIMIT, {4'h0, c});
            cyc(3);
            `CHK(privacy_pwm_en_o, c[3])
            if (c[3]) begin
                `CHK(privacy_pwm_code_o, c[2:0])
            end else begin
                `CHK({indicator_pulldown_o, indicator_level_o},
                    {c[2] && c[1:0] != 2'h0, c[1:0]})
            end
        end
        high_current_select_i = 1'b1;
        host.wr(`FLR_ADDR_LIMIT, 8'h05);
        cyc(4);
        `CHK(indicator_pulldown_o, 1'b0)
        dc_light_input_i = 1'b1;
        host.wr(`FLR_ADDR_LIMIT, 8'h08);
        cyc(4);
        `CHK(privacy_pwm_en_o, 1'b0)
        tdone("limit");
        // Power good and die temperature reads
        {power_good_i, die_temp_i} = 3'h6;
        cyc(5);
        host.rd(`FLR_ADDR_LIMIT, d);
        `CHK(d[7:5], 3'b110)
        thermal_trip_i = 1'b1;
        cyc(4);
        thermal_trip_i = 1'b0;
        cyc(4);
        host.rd(`FLR_ADDR_LIMIT, d);
        `CHK(d[6:5], 2'h3)
        host.rd(`FLR_ADDR_LIMIT, d);
        `CHK(d[6:5], 2'h2)
        // Pin routing: power good, then port value, then open drain
        host.wr(`FLR_ADDR_CAL, 8'h20);
        host.wr(`FLR_ADDR_LIMIT, 8'h00);
        cyc(3);
        `CHK({gpio_oe_o, gpio_o}, 2'b11)
        host.wr(`FLR_ADDR_LIMIT, 8'h80);
        cyc(3);
        `CHK({gpio_oe_o, gpio_o}, 2'b10)
        host.wr(`FLR_ADDR_CAL, 8'h38);
        cyc(3);
        `CHK(gpio_oe_o, 1'b0)
        // Enables, power save, pin reads, calibration
        gpio_i = 1'b1;
        host.wr(`FLR_ADDR_CAL, 8'h07);
        cyc(3);
        `CHK({power_save_o, led_enable_o}, 4'h7)
        host.rd(`FLR_ADDR_CAL, d);
        `CHK(d[5:0], 6'h37)
        host.wr(`FLR_ADDR_CAL, 8'h87);
        host.rd(`FLR_ADDR_CAL, d);
        `CHK(d[7], 1'b0)
        cal_done_i = 1'b1;
        cyc(4);
        host.rd(`FLR_ADDR_CAL, d);
        `CHK(d[7], 1'b1)
        tdone("pins");
        // Pin trigger in flash mode: level sensitive, then rising edge
        mode_i = `FLR_MODE_FLASH;
        for (i = 0; i < 2; i++) begin
            host.wr(`FLR_ADDR_TIMER, i ? 8'h14 : 8'h10);
            flash_sync_i = 1'b1;
            cyc(4);
            `CHK(strobe_active_o, 1'b1)
            flash_sync_i = 1'b0;
            cyc(4);
            `CHK(strobe_active_o, i[0])
        end
        repeat (300) if (strobe_active_o) @(negedge clk_i);
        host.rd(`FLR_ADDR_TIMER, d);
        `CHK(d[3:1], 3'b110)
        tdone("trigger");
        print_verdict;
    end
endmodule // flr_top_tb
bind flr_top flr_chk #(.TICK_CYCLES(TICK_CYCLES)) chk (.*);
